// File: common/fpprg_pkg.sv
package fpprg_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 250;
    localparam int T_GAP_MIN_US     = 1;     // Supply/select spacing, least
    localparam int T_GAP_MAX_US     = 1000;  // Supply/select spacing, most
    localparam int T_PULSE_MIN_US   = 15;
    localparam int T_PULSE_NOM_US   = 25;
    localparam int T_PULSE_MAX_US   = 100;
    localparam int T_PULSE_SURE_US  = 98;
    localparam int DUTY_MAX_PCT     = 35;
    localparam int DUTY_NOM_PCT     = 25;
    localparam int PULSE_NOM_CYC    = T_PULSE_NOM_US * CLK_MHZ;
    localparam int GAP_NOM_CYC      = T_GAP_MIN_US * CLK_MHZ * 2;
    localparam int US_CYC           = T_GAP_MIN_US * CLK_MHZ;
    localparam int GAP_MAX_CYC      = T_GAP_MAX_US * CLK_MHZ;
    localparam int PULSE_MIN_CYC    = T_PULSE_MIN_US * CLK_MHZ;
    localparam int PULSE_MAX_CYC    = T_PULSE_MAX_US * CLK_MHZ;
    // Off time so pulse/(pulse+off) stays at the nominal duty
    localparam int OFF_NOM_CYC      = PULSE_NOM_CYC * (100 - DUTY_NOM_PCT) / DUTY_NOM_PCT;
    localparam int CNT_W            = 20;

    // ------------------------------------------------------------
    // Device polarity
    // ------------------------------------------------------------
    localparam logic BLANK_LOW_VARIANT  = 1'b0;  // Blank low, fuses to high
    localparam logic BLANK_HIGH_VARIANT = 1'b1;  // Blank high, fuses to low

    typedef enum logic [3:0] {
        FP_IDLE    = 4'h0,
        FP_ADDR    = 4'h1,
        FP_READ    = 4'h2,
        FP_CHECK   = 4'h3,
        FP_DESEL   = 4'h4,
        FP_VPP_UP  = 4'h5,
        FP_PULSE   = 4'h6,
        FP_CS_OFF  = 4'h7,
        FP_VPP_DN  = 4'h8,
        FP_SETTLE  = 4'h9,
        FP_COOL    = 4'ha,
        FP_VERIFY  = 4'hb,
        FP_FINAL   = 4'hc,
        FP_DONE    = 4'hd
    } fpprg_state_t;

    typedef enum logic [1:0] {
        FP_VCC_NORM = 2'h0,
        FP_VCC_PROG = 2'h1,
        FP_VCC_LOW  = 2'h2,
        FP_VCC_HIGH = 2'h3
    } fpprg_vcc_t;

    // Pins toward the device
    typedef struct packed {
        logic [8:0]  addr;
        logic        cs_n;
        fpprg_vcc_t  vcc_sel;
        logic [7:0]  target_output_fuse_level;  // Pull selected output low
        logic [7:0]  term_en;                   // Load on unselected outputs
    } fpprg_pins_t;
endpackage

// File: rtl/fpprg_image.sv
`timescale 1ns/100ps
// Image of intended contents, written before a run, read by the sequencer.
module fpprg_image #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input  wire logic          clk_sys,  // System clock
    input  wire logic          wr_en,    // Write strobe
    input  wire logic [AW-1:0] wr_addr,  // Write address
    input  wire logic [DW-1:0] wr_data,  // Write data
    input  wire logic [AW-1:0] rd_addr,  // Read address
    output logic      [DW-1:0] rd_data   // Registered read data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// File: rtl/fpprg_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - At normal supply, address word and skip bits needing no fuse.
// - Drive chip selects high before fusing.
// - One bit per pulse; only its output pulled low, others terminated.
// - Raise supply to programming level before enabling chip selects.
// - Chip selects low 1 us to 1 ms after supply reaches level.
// - Pulse width 15 to 100 us, 25 nominal.
// - After the pulse, return chip selects high.
// - Lower supply 1 us to 1 ms after chip selects go high.
// - Verify read only 1 us after supply settles normal.
// - Repeat per bit, duty cycle at most 35 percent.
// - After all words, read back every word at both supply limits.
// - At most one fusing attempt per bit.
module fpprg_ctrl
    import fpprg_pkg::*;
#(
    parameter int AW          = 9,
    parameter int DW          = 8,
    parameter int PULSE_CYC   = PULSE_NOM_CYC,  // Fuse pulse length
    parameter int GAP_CYC     = GAP_NOM_CYC,    // Supply/select spacing
    parameter int OFF_CYC     = OFF_NOM_CYC,    // Rest between pulses
    parameter logic BLANK_HIGH = BLANK_LOW_VARIANT
) (
    input  wire logic              clk_sys,    // 250 MHz clock
    input  wire logic              arst_n,     // Async reset, active low
    input  wire logic              img_wr,     // Image write strobe
    input  wire logic [AW-1:0]     img_addr,   // Image write address
    input  wire logic [DW-1:0]     img_data,   // Image write data
    input  wire logic              start,      // Start pulse, runs from idle; in done returns to idle
    input  wire logic [DW-1:0]     dev_q,      // Device outputs, read back
    output fpprg_pkg::fpprg_pins_t pins,       // Pins toward the device
    output logic                   busy,       // Run in progress
    output logic                   done,       // Run finished, level
    output logic                   err,        // Mismatch seen, sticky
    output logic      [AW-1:0]     err_addr    // First mismatching word
);
    import fpprg_pkg::*;

    initial begin
        if (PULSE_CYC < PULSE_MIN_CYC || PULSE_CYC > PULSE_MAX_CYC) begin
            $error("pulse length out of range");
        end
        if (GAP_CYC < US_CYC || GAP_CYC > GAP_MAX_CYC) begin
            $error("supply spacing out of range");
        end
        if (OFF_CYC * DUTY_MAX_PCT < PULSE_CYC * (100 - DUTY_MAX_PCT)) begin
            $error("duty cycle above limit");
        end
        if (AW > 9 || DW > 8 || AW < 1 || DW < 1) begin
            $error("width unsupported");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        fpprg_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [AW-1:0]    addr;
        logic [2:0]       bit_i;
        logic             pass_hi;  // Second final-check pass
        logic             err;
        logic [AW-1:0]    err_addr;
        logic [DW-1:0]    rd;
        fpprg_pins_t      pins;
    } fpprg_regs_t;

    fpprg_regs_t s_q, s_d;
    logic [DW-1:0] want;

    fpprg_image #(.AW(AW), .DW(DW)) u_img (
        .clk_sys (clk_sys),
        .wr_en   (img_wr),
        .wr_addr (img_addr),
        .wr_data (img_data),
        .rd_addr (s_q.addr),
        .rd_data (want)
    );

    // Blank level of one bit of this variant
    function automatic logic blank_lvl();
        return BLANK_HIGH;
    endfunction

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction

    localparam logic [2:0] LAST_BIT = 3'(DW - 1);
    localparam logic [AW-1:0] LAST_ADDR = {AW{1'b1}};

    always_comb begin
        s_d = s_q;
        if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end else begin
            unique case (s_q.st)
                FP_IDLE: begin
                    if (start) begin
                        s_d.st = FP_ADDR;
                        s_d.addr = '0;
                        s_d.bit_i = '0;
                        s_d.err = 1'b0;
                        s_d.pass_hi = 1'b0;
                    end
                end
                FP_ADDR: begin
                    // Normal supply, word addressed, select low to read
                    s_d.pins.vcc_sel = FP_VCC_NORM;
                    s_d.pins.addr = 9'(s_q.addr);
                    s_d.pins.cs_n = 1'b0;
                    s_d.st = FP_READ;
                    s_d.cnt = cyc(US_CYC);
                end
                FP_READ: begin
                    s_d.rd = dev_q;
                    s_d.st = FP_CHECK;
                end
                FP_CHECK: begin
                    // Fuse only a bit still blank whose target differs; else skip
                    if (want[s_q.bit_i] != blank_lvl()
                        && s_q.rd[s_q.bit_i] == blank_lvl()) begin
                        s_d.st = FP_DESEL;
                    end else if (s_q.bit_i == LAST_BIT) begin
                        s_d.bit_i = '0;
                        if (s_q.addr == LAST_ADDR) begin
                            s_d.st = FP_FINAL;
                            s_d.pins.vcc_sel = FP_VCC_LOW;
                            s_d.addr = '0;
                            s_d.cnt = cyc(GAP_CYC);
                        end else begin
                            s_d.addr = s_q.addr + 1'b1;
                            s_d.st = FP_ADDR;
                        end
                    end else begin
                        s_d.bit_i = s_q.bit_i + 1'b1;
                    end
                end
                FP_DESEL: begin
                    s_d.pins.cs_n = 1'b1;
                    s_d.pins.target_output_fuse_level = 8'h00;
                    s_d.pins.target_output_fuse_level[s_q.bit_i] = 1'b1;
                    s_d.pins.term_en = ~s_d.pins.target_output_fuse_level;
                    s_d.st = FP_VPP_UP;
                    s_d.cnt = cyc(US_CYC);
                end
                FP_VPP_UP: begin
                    s_d.pins.vcc_sel = FP_VCC_PROG;
                    s_d.st = FP_PULSE;
                    s_d.cnt = cyc(GAP_CYC);
                end
                FP_PULSE: begin
                    s_d.pins.cs_n = 1'b0;
                    s_d.st = FP_CS_OFF;
                    s_d.cnt = cyc(PULSE_CYC);
                end
                FP_CS_OFF: begin
                    s_d.pins.cs_n = 1'b1;
                    s_d.st = FP_VPP_DN;
                    s_d.cnt = cyc(GAP_CYC);
                end
                FP_VPP_DN: begin
                    s_d.pins.vcc_sel = FP_VCC_NORM;
                    s_d.pins.target_output_fuse_level = 8'h00;
                    s_d.pins.term_en = 8'hff;
                    s_d.st = FP_SETTLE;
                    s_d.cnt = cyc(GAP_CYC);
                end
                FP_SETTLE: begin
                    s_d.pins.cs_n = 1'b0;
                    s_d.st = FP_VERIFY;
                    s_d.cnt = cyc(US_CYC);
                end
                FP_VERIFY: begin
                    // Flag, never re-pulse
                    if (dev_q[s_q.bit_i] == blank_lvl() && !s_q.err) begin
                        s_d.err = 1'b1;
                        s_d.err_addr = s_q.addr;
                    end
                    s_d.rd = dev_q;
                    s_d.rd[s_q.bit_i] = ~blank_lvl();  // Bit done, no retry
                    s_d.st = FP_COOL;
                    s_d.cnt = cyc(OFF_CYC);
                end
                FP_COOL: begin
                    s_d.st = FP_CHECK;
                end
                FP_FINAL: begin
                    s_d.pins.cs_n = 1'b0;
                    s_d.pins.addr = 9'(s_q.addr);
                    if (s_q.pins.addr == 9'(s_q.addr) && !s_q.pins.cs_n) begin
                        if (dev_q != want && !s_q.err) begin
                            s_d.err = 1'b1;
                            s_d.err_addr = s_q.addr;
                        end
                        if (s_q.addr == LAST_ADDR) begin
                            s_d.addr = '0;
                            s_d.pins.cs_n = 1'b1;
                            if (s_q.pass_hi) begin
                                s_d.st = FP_DONE;
                                s_d.pins.vcc_sel = FP_VCC_NORM;
                            end else begin
                                s_d.pass_hi = 1'b1;
                                s_d.pins.vcc_sel = FP_VCC_HIGH;
                                s_d.cnt = cyc(GAP_CYC);
                            end
                        end else begin
                            s_d.addr = s_q.addr + 1'b1;
                        end
                    end else begin
                        s_d.cnt = cyc(US_CYC);  // Access settle
                    end
                end
                FP_DONE: begin
                    s_d.pins.cs_n = 1'b1;
                    if (start) begin
                        s_d.st = FP_IDLE;
                    end
                end
                default: s_d.st = FP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{st: FP_IDLE, cnt: '0, addr: '0, bit_i: '0, pass_hi: 1'b0,
                     err: 1'b0, err_addr: '0, rd: '0,
                     pins: '{addr: '0, cs_n: 1'b1, vcc_sel: FP_VCC_NORM,
                             target_output_fuse_level: 8'h00, term_en: 8'hff}};
        end else begin
            s_q <= s_d;
        end
    end

    assign pins     = s_q.pins;
    assign busy     = (s_q.st != FP_IDLE) && (s_q.st != FP_DONE);
    assign done     = (s_q.st == FP_DONE);
    assign err      = s_q.err;
    assign err_addr = s_q.err_addr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_desel_before_vpp;
        @(posedge clk_sys) disable iff (!arst_n)
        (pins.vcc_sel == FP_VCC_PROG && $past(pins.vcc_sel) != FP_VCC_PROG) |-> pins.cs_n;
    endproperty
    a_desel_before_vpp: assert property (p_desel_before_vpp)
        else $error("supply raised with select low");

    property p_one_bit;
        @(posedge clk_sys) disable iff (!arst_n)
        (pins.vcc_sel == FP_VCC_PROG) |-> $onehot(pins.target_output_fuse_level)
            && (pins.term_en == ~pins.target_output_fuse_level);
    endproperty
    a_one_bit: assert property (p_one_bit)
        else $error("not exactly one bit driven");

    property p_cs_only_at_vpp;
        @(posedge clk_sys) disable iff (!arst_n)
        ($fell(pins.cs_n) && pins.target_output_fuse_level != 8'h00)
            |-> pins.vcc_sel == FP_VCC_PROG;
    endproperty
    a_cs_only_at_vpp: assert property (p_cs_only_at_vpp)
        else $error("pulse without programming supply");

    property p_gap_before_pulse;
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(pins.vcc_sel == FP_VCC_PROG) |-> pins.cs_n [*2];
    endproperty
    a_gap_before_pulse: assert property (p_gap_before_pulse)
        else $error("select enabled too soon");

    // Spans too long for a delay range are counted here instead
    logic [CNT_W-1:0] pulse_len_q;
    logic [CNT_W-1:0] vpp_hold_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pulse_len_q <= '0;
            vpp_hold_q  <= '0;
        end else begin
            if (!pins.cs_n && pins.vcc_sel == FP_VCC_PROG) begin
                pulse_len_q <= pulse_len_q + 1'b1;
            end else begin
                pulse_len_q <= '0;
            end
            if (pins.cs_n && pins.vcc_sel == FP_VCC_PROG && pulse_len_q != '0) begin
                vpp_hold_q <= 20'h00001;
            end else if (pins.vcc_sel == FP_VCC_PROG && vpp_hold_q != '0) begin
                vpp_hold_q <= vpp_hold_q + 1'b1;
            end else begin
                vpp_hold_q <= '0;
            end
        end
    end

    property p_pulse_ends;
        @(posedge clk_sys) disable iff (!arst_n)
        pulse_len_q <= CNT_W'(PULSE_MAX_CYC);
    endproperty
    a_pulse_ends: assert property (p_pulse_ends)
        else $error("pulse too long");

    property p_pulse_min;
        @(posedge clk_sys) disable iff (!arst_n)
        ($fell(pins.cs_n) && pins.vcc_sel == FP_VCC_PROG) |-> !pins.cs_n [*8];
    endproperty
    a_pulse_min: assert property (p_pulse_min)
        else $error("pulse cut short");

    property p_vpp_drop;
        @(posedge clk_sys) disable iff (!arst_n)
        vpp_hold_q <= CNT_W'(GAP_MAX_CYC);
    endproperty
    a_vpp_drop: assert property (p_vpp_drop)
        else $error("supply not lowered in time");

    property p_verify_wait;
        @(posedge clk_sys) disable iff (!arst_n)
        $fell(pins.vcc_sel == FP_VCC_PROG) |-> pins.cs_n [*2];
    endproperty
    a_verify_wait: assert property (p_verify_wait)
        else $error("verify too soon");
endmodule

// File: verif/fpprg_prom_model.sv
`timescale 1ns/100ps
module fpprg_prom_model
    import fpprg_pkg::*;
#(
    parameter logic BLANK_HIGH = BLANK_LOW_VARIANT
) (
    input  wire logic        clk_sys,  // Clock used to time the pins
    input  wire fpprg_pins_t pins,     // Pins from the programmer
    input  wire logic [7:0]  stuck,    // Links that refuse to open
    output logic      [7:0]  dev_q,    // Data outputs
    output logic      [7:0]  n_viol,   // Programmer timing, bit selection and repeat-pulse faults
    output logic      [7:0]  n_pulse,  // Fusing pulses taken
    output logic      [3:0]  seen_lo,  // Words read at low supply
    output logic      [3:0]  seen_hi   // Words read at high supply
);
    // ----------------------------------------
    // Array state and pin history
    // ----------------------------------------
    logic [7:0]  fused [4] = '{default: 8'h00};
    logic [7:0]  tried [4] = '{default: 8'h00};
    logic [7:0]  last_q    = 8'h00;
    fpprg_pins_t pins_q    = '1;
    int          vcc_cnt   = GAP_MAX_CYC;
    int          cs_cnt    = 0;
    int          since     = GAP_MAX_CYC;
    int          last_w    = 0;
    logic        prog;
    logic        prog_q;
    logic        sel;
    logic [1:0]  wa;
    logic [1:0]  qa;
    logic [7:0]  fq;

    initial begin
        n_viol  = 8'h00;
        n_pulse = 8'h00;
        seen_lo = 4'h0;
        seen_hi = 4'h0;
    end

    assign prog   = pins.vcc_sel == FP_VCC_PROG;
    assign prog_q = pins_q.vcc_sel == FP_VCC_PROG;
    assign sel    = !pins.cs_n && !prog;
    assign wa     = pins.addr[1:0];
    assign qa     = pins_q.addr[1:0];
    assign fq     = pins_q.target_output_fuse_level;
    // Released outputs show the inverse, so a stale word never passes
    assign dev_q = sel ? fused[wa] ^ {8{BLANK_HIGH}} : ~last_q;

    // ----------------------------------------
    // Sequence timing and fusing
    // ----------------------------------------
    always @(posedge clk_sys) begin
        pins_q  <= pins;
        vcc_cnt <= (prog != prog_q) ? 1 : vcc_cnt + 1;
        cs_cnt  <= (pins.cs_n != pins_q.cs_n) ? 1 : cs_cnt + 1;
        since   <= since + 1;
        if (sel) begin
            last_q <= dev_q;
            if (pins.vcc_sel == FP_VCC_LOW) seen_lo[wa] <= 1'b1;
            if (pins.vcc_sel == FP_VCC_HIGH) seen_hi[wa] <= 1'b1;
        end
        if (prog && !prog_q && !pins.cs_n) n_viol <= n_viol + 1;
        if (!pins.cs_n && pins_q.cs_n) begin
            if (prog && (vcc_cnt < US_CYC || vcc_cnt > GAP_MAX_CYC)
                    || !prog && vcc_cnt < US_CYC
                    || prog && n_pulse != 0 && last_w * 100 > DUTY_MAX_PCT * since)
                n_viol <= n_viol + 1;
            if (prog) since <= 1;
        end
        if (pins.cs_n && !pins_q.cs_n && prog) begin
            last_w  <= cs_cnt;
            n_pulse <= n_pulse + 1;
            if (cs_cnt < PULSE_MIN_CYC || cs_cnt > PULSE_MAX_CYC
                    || !$onehot(fq) || pins_q.term_en != ~fq
                    || |(tried[qa] & fq))
                n_viol <= n_viol + 1;
            tried[qa] <= tried[qa] | fq;
            // Any pulse ended at programming supply opens a link unless stuck; reads never reach it
            fused[qa] <= fused[qa] | (fq & ~stuck);
        end
        if (!prog && prog_q && (!pins.cs_n || cs_cnt < US_CYC || cs_cnt > GAP_MAX_CYC))
            n_viol <= n_viol + 1;
    end
endmodule

// File: verif/fpprg_ctrl_tb_top.sv
`timescale 1ns/100ps
module fpprg_ctrl_tb_top;
    import fpprg_pkg::*;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    logic        clk_sys    = 1'b0;
    logic        arst_n     = 1'b0;
    logic        img_wr     = 1'b0;
    logic [1:0]  img_addr   = 2'h0;
    logic [7:0]  img_data   = 8'h00;
    logic        start      = 1'b0;
    logic [7:0]  stuck      = 8'h00;
    logic [7:0]  dev_q;
    logic [7:0]  n_viol;
    logic [7:0]  n_pulse;
    logic [3:0]  seen_lo;
    logic [3:0]  seen_hi;
    logic [1:0]  err_addr;
    logic        busy;
    logic        done;
    logic        err;
    fpprg_pins_t pins;
    int          failures   = 0;
    int          n_compared = 0;

    always #2 clk_sys = ~clk_sys;

    // Short pulse and rest keep the run small; duty stays near nominal
    fpprg_ctrl #(
        .AW(2), .DW(8), .PULSE_CYC(3750), .GAP_CYC(250), .OFF_CYC(11250),
        .BLANK_HIGH(BLANK_LOW_VARIANT)
    ) fpprg_ctrl_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .img_wr(img_wr), .img_addr(img_addr),
        .img_data(img_data), .start(start), .dev_q(dev_q), .pins(pins), .busy(busy),
        .done(done), .err(err), .err_addr(err_addr)
    );
    fpprg_prom_model #(.BLANK_HIGH(BLANK_LOW_VARIANT)) fpprg_prom_model_inst (
        .clk_sys(clk_sys), .pins(pins), .stuck(stuck), .dev_q(dev_q), .n_viol(n_viol),
        .n_pulse(n_pulse), .seen_lo(seen_lo), .seen_hi(seen_hi)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic load(logic [31:0] img);  // Word k in byte k
        for (int i = 0; i < 4; i++) begin
            img_wr   = 1'b1;
            img_addr = i[1:0];
            img_data = img[8*i +: 8];
            @(negedge clk_sys);
        end
        img_wr = 1'b0;
    endtask

    task automatic pulse_start();
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic run(int poke);  // Poke: cycles before a start that must be ignored
        if (done === 1'b1) begin
            pulse_start();
            check("done_cleared", done, 1'b0);
        end
        pulse_start();
        check("busy", busy, 1'b1);
        if (poke > 0) begin
            repeat (poke) @(negedge clk_sys);
            pulse_start();
            check("busy_kept", busy, 1'b1);
        end
        for (int i = 0; i < 70000 && done !== 1'b1; i++) @(negedge clk_sys);
        check("done", done, 1'b1);
        check("busy_end", busy, 1'b0);
        check("timing_a", n_viol, 8'h00);
        check("timing_b", n_viol, 8'h00);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        repeat (2) @(negedge clk_sys);
        check("cs_rst", pins.cs_n, 1'b1);
        check("vcc_rst", pins.vcc_sel, FP_VCC_NORM);
        check("term_rst", pins.term_en, 8'hff);
        check("flags_rst", {busy, done, err}, 3'h0);
        arst_n = 1'b1;
        @(negedge clk_sys);
    endtask

    task automatic t_fuse();
        load(32'h0080_0100);
        run(0);
        check("err1", err, 1'b0);
        check("pulses1", n_pulse, 8'h02);
        for (int i = 0; i < 4; i++)
            check("fused1", fpprg_prom_model_inst.fused[i], 8'(32'h0080_0100 >> 8*i));
        check("both_limits", {seen_lo, seen_hi}, 8'hff);
    endtask

    task automatic t_stuck();
        stuck = 8'h01;
        load(32'h0180_0100);
        run(400);
        check("err2", err, 1'b1);
        check("err_addr", err_addr, 2'h3);
        check("pulses2", n_pulse, 8'h03);
        repeat (20) @(negedge clk_sys);
        check("done_held", {done, err}, 2'h3);
    endtask

    task automatic t_clean();
        stuck = 8'h00;
        load(32'h0080_0100);
        run(0);
        check("err3", err, 1'b0);
        check("pulses3", n_pulse, 8'h03);
        check("word1", fpprg_prom_model_inst.fused[1], 8'h01);
    endtask

    initial begin
        t_reset();
        t_fuse();
        t_stuck();
        t_clean();
        summarize();
    end

    // Three fuses take near 49000 cycles, the three runs in all near 60000
    initial begin
        repeat (100000) @(posedge clk_sys);
        failures++;
        summarize();
    end
endmodule
